/* src/tsa_pkg.sv */
// Purpose: Constants for the time-slot assignment block
// Assumes: AXI4-Lite, 32-bit data, one register per word
// Notes: Offsets are register indices; byte address is index times four
package tsa_pkg;
  // Register indices as printed; not all multiples of four
  localparam logic [7:0] TSA_TX_SHIFT_IDX = 8'h28;
  localparam logic [7:0] TSA_TX_START_IDX = 8'h29;
  localparam logic [7:0] TSA_TX_WLOW_IDX = 8'h2a;
  localparam logic [7:0] TSA_TX_WHIGH_IDX = 8'h2b;
  localparam logic [7:0] TSA_RX_SHIFT_IDX = 8'h2c;
  localparam logic [7:0] TSA_RX_START_IDX = 8'h2d;
  localparam logic [7:0] TSA_RX_WLOW_IDX = 8'h2e;
  localparam logic [7:0] TSA_RX_WHIGH_IDX = 8'h2f;
  localparam logic [7:0] TSA_TX_MASK0_IDX = 8'h30;
  localparam logic [7:0] TSA_RX_MASK0_IDX = 8'h34;
  localparam logic [7:0] TSA_CTRL_IDX = 8'h3c;
  localparam logic [7:0] TSA_STAT_IDX = 8'h3d;
  localparam int TSA_MASK_REGS = 4;
  localparam logic [7:0] TSA_REG_RESET = 8'h00;
  localparam int TSA_SHIFT_W = 3;
  localparam int TSA_NUM_W = 7;
  localparam int TSA_CAP_W = 9;
  localparam int TSA_ENA_BIT = 7;
  localparam int TSA_SLOT_BITS = 8;
  localparam int TSA_MASK_SLOTS = 32;
  localparam int TSA_CNT_W = 11;
  localparam logic [1:0] TSA_RESP_OKAY = 2'b00;
  localparam logic [1:0] TSA_RESP_SLVERR = 2'b10;
  // Control register: bit 0 selects time-slot clock mode
  localparam int TSA_CTRL_MODE_BIT = 0;
endpackage : tsa_pkg

/* src/tsa_slot_assign.sv */
// Purpose: Time-slot assignment for one channel of a TDM serial port
// Assumes: Link clock and frame sync come from the highway
// Notes: Config crosses to the link domain through two-flop level sync
// Summary of operation
// RQ1: Three-bit transmit clock shift moves the transmit slot start.
// RQ2: Mask enable low: transmit slot from start offset and capacity.
// RQ3: Mask enable high: eight-bit transmit slots at offset, capacity ignored.
// RQ4: Mask mode transmits only in slots whose mask bit is set.
// RQ5: Transmit start is 1 plus 8 times slot number plus shift.
// RQ6: Slot fields act only in time-slot clock mode.
// RQ7: Standard transmit width equals capacity plus one bits.
// RQ8: Three-bit receive clock shift moves the receive slot start.
// RQ9: Mask enable low: receive slot from start offset and capacity.
// RQ10: Mask enable high: eight-bit receive slots, capacity ignored.
// RQ11: Mask mode receives only in slots whose mask bit is set.
// RQ12: Receive start is 1 plus 8 times slot number plus shift.
// RQ13: Standard receive width equals capacity plus one bits.
// RQ14: Each mask has 32 bits for 32 consecutive eight-bit slots.
// RQ15: Slot bit counter restarts at every frame sync pulse.
// RQ16: Unused shift register bits read zero and ignore writes.
//
// Implementation choice: the AXI4-Lite register port.
module tsa_slot_assign
  import tsa_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic linkClk,
  input wire logic linkRst,
  input wire logic frameSync,
  output logic txSlotActive,
  output logic rxSlotActive
);

  initial begin
    if (ADDR_W < 10) begin
      $error("ADDR_W too small for register map");
    end
  end

  // Configuration registers
  logic [TSA_SHIFT_W-1:0] txShift_ff;
  logic [7:0] txStart_ff;
  logic [7:0] txWLow_ff;
  logic txWHigh_ff;
  logic [TSA_SHIFT_W-1:0] rxShift_ff;
  logic [7:0] rxStart_ff;
  logic [7:0] rxWLow_ff;
  logic rxWHigh_ff;
  logic [TSA_MASK_SLOTS-1:0] txMask_ff;
  logic [TSA_MASK_SLOTS-1:0] rxMask_ff;
  logic slotMode_ff;

  // AXI write side
  logic awHeld_ff;
  logic [ADDR_W-1:0] awAddr_ff;
  logic wHeld_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  logic [ADDR_W-3:0] wIdx;
  logic wHit;

  assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  assign wIdx = awAddr_ff[ADDR_W-1:2];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !awHeld_ff && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (doWrite) begin
        awHeld_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wHeld_ff <= 1'b0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !wHeld_ff && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (doWrite) begin
        wHeld_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    wHit = 1'b1;
    if (wIdx == {2'b00, TSA_TX_SHIFT_IDX}) begin
      wHit = 1'b1;
    end else if (wIdx[ADDR_W-3:3] == {2'b00, TSA_TX_SHIFT_IDX[7:3]}) begin
      wHit = 1'b1;
    end else if (wIdx == {2'b00, TSA_CTRL_IDX}) begin
      wHit = 1'b1;
    end else if (wIdx == {2'b00, TSA_STAT_IDX}) begin
      wHit = 1'b1;
    end else if (wIdx[ADDR_W-3:2] == {2'b00, TSA_TX_MASK0_IDX[7:2]}) begin
      wHit = 1'b1;
    end else if (wIdx[ADDR_W-3:2] == {2'b00, TSA_RX_MASK0_IDX[7:2]}) begin
      wHit = 1'b1;
    end else begin
      wHit = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TSA_RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wHit ? TSA_RESP_OKAY : TSA_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txShift_ff <= '0;
      txStart_ff <= TSA_REG_RESET;
      txWLow_ff <= TSA_REG_RESET;
      txWHigh_ff <= 1'b0;
      rxShift_ff <= '0;
      rxStart_ff <= TSA_REG_RESET;
      rxWLow_ff <= TSA_REG_RESET;
      rxWHigh_ff <= 1'b0;
      slotMode_ff <= 1'b0;
    end else if (doWrite && wStrb_ff[0]) begin
      if (wIdx == {2'b00, TSA_TX_SHIFT_IDX}) begin
        txShift_ff <= wData_ff[TSA_SHIFT_W-1:0]; // RQ16
      end else if (wIdx == {2'b00, TSA_TX_START_IDX}) begin
        txStart_ff <= wData_ff[7:0];
      end else if (wIdx == {2'b00, TSA_TX_WLOW_IDX}) begin
        txWLow_ff <= wData_ff[7:0];
      end else if (wIdx == {2'b00, TSA_TX_WHIGH_IDX}) begin
        txWHigh_ff <= wData_ff[0];
      end else if (wIdx == {2'b00, TSA_RX_SHIFT_IDX}) begin
        rxShift_ff <= wData_ff[TSA_SHIFT_W-1:0]; // RQ16
      end else if (wIdx == {2'b00, TSA_RX_START_IDX}) begin
        rxStart_ff <= wData_ff[7:0];
      end else if (wIdx == {2'b00, TSA_RX_WLOW_IDX}) begin
        rxWLow_ff <= wData_ff[7:0];
      end else if (wIdx == {2'b00, TSA_RX_WHIGH_IDX}) begin
        rxWHigh_ff <= wData_ff[0];
      end else if (wIdx == {2'b00, TSA_CTRL_IDX}) begin
        slotMode_ff <= wData_ff[TSA_CTRL_MODE_BIT];
      end
    end
  end

  // Mask bytes, one register per byte of the 32 slot bits
  for (genvar g = 0; g < TSA_MASK_REGS; g++) begin : g_mask
    always_ff @(posedge core_clk) begin
      if (rst) begin
        txMask_ff[g*8 +: 8] <= TSA_REG_RESET;
        rxMask_ff[g*8 +: 8] <= TSA_REG_RESET;
      end else if (doWrite && wStrb_ff[0]) begin
        if (wIdx == {2'b00, TSA_TX_MASK0_IDX + 8'(g)}) begin
          txMask_ff[g*8 +: 8] <= wData_ff[7:0]; // RQ14
        end else if (wIdx == {2'b00, TSA_RX_MASK0_IDX + 8'(g)}) begin
          rxMask_ff[g*8 +: 8] <= wData_ff[7:0]; // RQ14
        end
      end
    end
  end

  // Link-side status synchronised back for reads
  logic txActS1_ff;
  logic txActS2_ff;
  logic rxActS1_ff;
  logic rxActS2_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      txActS1_ff <= 1'b0;
      txActS2_ff <= 1'b0;
      rxActS1_ff <= 1'b0;
      rxActS2_ff <= 1'b0;
    end else begin
      txActS1_ff <= txSlotActive;
      txActS2_ff <= txActS1_ff;
      rxActS1_ff <= rxSlotActive;
      rxActS2_ff <= rxActS1_ff;
    end
  end

  // AXI read side
  logic [ADDR_W-3:0] rIdx;
  logic [31:0] nxt_rdata;
  logic nxt_rerr;

  assign rIdx = s_axi_araddr[ADDR_W-1:2];

  always_comb begin
    nxt_rdata = '0;
    nxt_rerr = 1'b0;
    if (rIdx == {2'b00, TSA_TX_SHIFT_IDX}) begin
      nxt_rdata[TSA_SHIFT_W-1:0] = txShift_ff; // RQ16
    end else if (rIdx == {2'b00, TSA_TX_START_IDX}) begin
      nxt_rdata[7:0] = txStart_ff;
    end else if (rIdx == {2'b00, TSA_TX_WLOW_IDX}) begin
      nxt_rdata[7:0] = txWLow_ff;
    end else if (rIdx == {2'b00, TSA_TX_WHIGH_IDX}) begin
      nxt_rdata[0] = txWHigh_ff;
    end else if (rIdx == {2'b00, TSA_RX_SHIFT_IDX}) begin
      nxt_rdata[TSA_SHIFT_W-1:0] = rxShift_ff; // RQ16
    end else if (rIdx == {2'b00, TSA_RX_START_IDX}) begin
      nxt_rdata[7:0] = rxStart_ff;
    end else if (rIdx == {2'b00, TSA_RX_WLOW_IDX}) begin
      nxt_rdata[7:0] = rxWLow_ff;
    end else if (rIdx == {2'b00, TSA_RX_WHIGH_IDX}) begin
      nxt_rdata[0] = rxWHigh_ff;
    end else if (rIdx[ADDR_W-3:2] == {2'b00, TSA_TX_MASK0_IDX[7:2]}) begin
      nxt_rdata[7:0] = txMask_ff[rIdx[1:0]*8 +: 8];
    end else if (rIdx[ADDR_W-3:2] == {2'b00, TSA_RX_MASK0_IDX[7:2]}) begin
      nxt_rdata[7:0] = rxMask_ff[rIdx[1:0]*8 +: 8];
    end else if (rIdx == {2'b00, TSA_CTRL_IDX}) begin
      nxt_rdata[TSA_CTRL_MODE_BIT] = slotMode_ff;
    end else if (rIdx == {2'b00, TSA_STAT_IDX}) begin
      nxt_rdata[1:0] = {rxActS2_ff, txActS2_ff};
    end else begin
      nxt_rerr = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= TSA_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= nxt_rdata;
        s_axi_rresp <= nxt_rerr ? TSA_RESP_SLVERR : TSA_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Link domain: config is quasi-static, so per-bit two-flop sync suffices
  // Software must change config between frames to avoid a torn slot
  localparam int CFG_W = 2 * (TSA_SHIFT_W + 8 + TSA_CAP_W + TSA_MASK_SLOTS) + 1;
  logic [CFG_W-1:0] cfgAll;
  logic [CFG_W-1:0] cfgS1_ff;
  logic [CFG_W-1:0] cfgS2_ff;
  logic fsS1_ff;
  logic fsS2_ff;
  logic fsPrev_ff;

  assign cfgAll = {slotMode_ff, txShift_ff, txStart_ff, txWHigh_ff, txWLow_ff, txMask_ff,
                   rxShift_ff, rxStart_ff, rxWHigh_ff, rxWLow_ff, rxMask_ff};

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      cfgS1_ff <= '0;
      cfgS2_ff <= '0;
      fsS1_ff <= 1'b0;
      fsS2_ff <= 1'b0;
      fsPrev_ff <= 1'b0;
    end else begin
      cfgS1_ff <= cfgAll;
      cfgS2_ff <= cfgS1_ff;
      fsS1_ff <= frameSync;
      fsS2_ff <= fsS1_ff;
      fsPrev_ff <= fsS2_ff;
    end
  end

  logic lMode;
  logic [TSA_SHIFT_W-1:0] lTxShift;
  logic [7:0] lTxStart;
  logic [TSA_CAP_W-1:0] lTxCap;
  logic [TSA_MASK_SLOTS-1:0] lTxMask;
  logic [TSA_SHIFT_W-1:0] lRxShift;
  logic [7:0] lRxStart;
  logic [TSA_CAP_W-1:0] lRxCap;
  logic [TSA_MASK_SLOTS-1:0] lRxMask;
  logic fsPulse;

  assign {lMode, lTxShift, lTxStart, lTxCap, lTxMask,
          lRxShift, lRxStart, lRxCap, lRxMask} = cfgS2_ff;
  assign fsPulse = fsS2_ff && !fsPrev_ff;

  // Clock count after frame sync; first clock after sync is 1
  logic [TSA_CNT_W:0] bitCnt_ff;

  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      bitCnt_ff <= '0;
    end else if (fsPulse) begin
      bitCnt_ff <= '0; // RQ15
    end else if (!bitCnt_ff[TSA_CNT_W]) begin
      bitCnt_ff <= bitCnt_ff + 1'b1;
    end
  end

  // Slot decision per direction: index 0 transmit, 1 receive
  logic [1:0] nxt_act;
  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic [TSA_SHIFT_W-1:0] sh;
    logic [7:0] st;
    logic [TSA_CAP_W-1:0] cap;
    logic [TSA_MASK_SLOTS-1:0] msk;
    logic [TSA_CNT_W:0] startPos;
    logic [TSA_CNT_W:0] rel;
    logic [TSA_CNT_W:0] nxtCnt;
    assign sh = (d == 0) ? lTxShift : lRxShift; // RQ1 RQ8
    assign st = (d == 0) ? lTxStart : lRxStart;
    assign cap = (d == 0) ? lTxCap : lRxCap;
    assign msk = (d == 0) ? lTxMask : lRxMask;
    assign nxtCnt = fsPulse ? '0 : bitCnt_ff + 1'b1;
    // Offset = 1 + 8*number + shift
    assign startPos = 12'd1 + {2'b00, st[TSA_NUM_W-1:0], 3'b000} + {9'd0, sh}; // RQ5 RQ12
    assign rel = nxtCnt - startPos;
    always_comb begin
      nxt_act[d] = 1'b0;
      if (!lMode || fsPulse || nxtCnt < startPos || bitCnt_ff[TSA_CNT_W]) begin
        nxt_act[d] = 1'b0; // RQ6
      end else if (st[TSA_ENA_BIT]) begin
        // Eight-bit slots gated by mask; capacity ignored
        if (rel < 12'(TSA_SLOT_BITS * TSA_MASK_SLOTS)) begin
          nxt_act[d] = msk[rel[7:3]]; // RQ3 RQ4 RQ10 RQ11 RQ14
        end
      end else begin
        nxt_act[d] = rel <= {3'b000, cap}; // RQ2 RQ7 RQ9 RQ13
      end
    end
  end

  // Active flag covers the clock period counted since frame sync
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      txSlotActive <= 1'b0;
      rxSlotActive <= 1'b0;
    end else begin
      txSlotActive <= nxt_act[0];
      rxSlotActive <= nxt_act[1];
    end
  end

  bresp_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  shift_upper_a: assert property (@(posedge core_clk) disable iff (rst) // RQ16
    doWrite && wIdx == {2'b00, TSA_TX_SHIFT_IDX} && wStrb_ff[0]
      |=> txShift_ff == $past(wData_ff[2:0]))
    else $error("shift write wrong");
  sync_restart_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ15
    fsPulse |=> bitCnt_ff == 0)
    else $error("counter not restarted");
  mode_gate_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ6
    !lMode |=> !txSlotActive && !rxSlotActive)
    else $error("active outside slot mode");
  tx_start_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ5
    lMode && !fsPulse && !bitCnt_ff[TSA_CNT_W] && bitCnt_ff + 1 < g_dir[0].startPos
      |=> !txSlotActive)
    else $error("tx active before start");
  rx_start_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ12
    lMode && !fsPulse && !bitCnt_ff[TSA_CNT_W] && bitCnt_ff + 1 < g_dir[1].startPos
      |=> !rxSlotActive)
    else $error("rx active before start");
  tx_width_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ7
    lMode && !lTxStart[TSA_ENA_BIT] && !fsPulse && g_dir[0].rel > {3'b000, lTxCap}
      |=> !txSlotActive)
    else $error("tx slot too wide");
  rx_width_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ13
    lMode && !lRxStart[TSA_ENA_BIT] && !fsPulse && g_dir[1].rel > {3'b000, lRxCap}
      |=> !rxSlotActive)
    else $error("rx slot too wide");
  tx_mask_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ4
    lMode && lTxStart[TSA_ENA_BIT] && !fsPulse && g_dir[0].nxtCnt >= g_dir[0].startPos
      && g_dir[0].rel < 256 && !lTxMask[g_dir[0].rel[7:3]] |=> !txSlotActive)
    else $error("tx in unmasked slot");
  rx_mask_a: assert property (@(posedge linkClk) disable iff (linkRst) // RQ11
    lMode && lRxStart[TSA_ENA_BIT] && !fsPulse && g_dir[1].nxtCnt >= g_dir[1].startPos
      && g_dir[1].rel < 256 && !lRxMask[g_dir[1].rel[7:3]] |=> !rxSlotActive)
    else $error("rx in unmasked slot");

endmodule : tsa_slot_assign

/* testbench/tsa_highway.sv */
// Purpose: Behavioural TDM highway, bit clock and frame sync
// Assumes: Bit clock stands still between frames
// Notes: 32 ns period, phase unrelated to the core clock
module tsa_highway (
  output logic linkClk,
  output logic frameSync
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    linkClk = 1'b0;
    frameSync = 1'b0;
  end
  // Runs n bit clocks with frame sync low; used while link reset is applied
  task automatic runClocks(input int n);
    repeat (n) begin
      #16 linkClk = 1'b1;
      #16 linkClk = 1'b0;
    end
  endtask : runClocks
  // Idle lead bits let new config settle before sync
  task automatic frame(input int lead, input int len);
    for (int i = 0; i < lead + len; i++) begin
      #16 linkClk = 1'b1;
      #3 frameSync = (i == lead - 1);
      #13 linkClk = 1'b0;
    end
  endtask : frame
endmodule : tsa_highway

/* testbench/tb_tsa_slot_assign.sv */
// Purpose: Self-checking bench for the time-slot assignment block
// Assumes: Output for count 1 is sampled three bit clocks after sync
// Notes: Slot activity compared bit by bit with a reference function
module tb_tsa_slot_assign
  import tsa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] sh;
    logic en;
    logic [6:0] num;
    logic [8:0] cap;
    logic [31:0] mask;
  } tsa_dir_s;
  // Boundaries: widest slot, last start, slot 31, 9-bit capacity
  localparam tsa_dir_s TX_TAB [5] = '{{3'd0, 1'b0, 7'd0, 9'd0, 32'h0},
    {3'd7, 1'b0, 7'd3, 9'd20, 32'hffffffff}, {3'd3, 1'b1, 7'd1, 9'd5, 32'h80000005},
    {3'd0, 1'b0, 7'd0, 9'd511, 32'h0}, {3'd7, 1'b0, 7'd3, 9'd20, 32'h0}};
  localparam tsa_dir_s RX_TAB [5] = '{{3'd0, 1'b0, 7'd0, 9'd0, 32'h0},
    {3'd2, 1'b0, 7'd5, 9'd256, 32'hffffffff}, {3'd0, 1'b1, 7'd2, 9'd511, 32'h00000102},
    {3'd7, 1'b0, 7'd127, 9'd0, 32'h0}, {3'd0, 1'b1, 7'd0, 9'd0, 32'hffffffff}};
  localparam logic MODE_TAB [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic core_clk, rst, linkRst, linkClk, frameSync, txSlotActive, rxSlotActive;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdData;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic txSeen [0:2047];
  logic rxSeen [0:2047];
  int failCount = 0;
  int nTests = 0;
  int cycles = 0;
  int pos = 4095;
  tsa_slot_assign #(.ADDR_W(12)) i_tsa_slot_assign (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .linkClk(linkClk),
    .linkRst(linkRst), .frameSync(frameSync), .txSlotActive(txSlotActive),
    .rxSlotActive(rxSlotActive));
  tsa_highway i_tsa_highway (.linkClk(linkClk), .frameSync(frameSync));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Position zero is the edge that first sees sync high
  always @(posedge linkClk) begin
    if (frameSync) pos = 0;
    else if (pos < 4095) pos = pos + 1;
  end
  always @(negedge linkClk) begin
    if (pos < 2048) begin
      txSeen[pos] = txSlotActive;
      rxSeen[pos] = rxSlotActive;
    end
  end
  task automatic tallyAndFinish();
    if (failCount == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tallyAndFinish
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      failCount++;
      tallyAndFinish();
    end
  end
  task automatic checkEq(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : checkEq
  task automatic axiWrite(input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] idx, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axiRead
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    axiWrite(idx, d, 4'hf, resp);
  endtask : wr
  task automatic rdChk(input logic [7:0] idx, input logic [31:0] exp);
    axiRead(idx, rdData, resp);
    checkEq({rdData[31:2], rdData[1:0] ^ resp}, exp);
  endtask : rdChk
  task automatic cfgDir(input logic [7:0] b, input logic [7:0] m, input tsa_dir_s c);
    wr(b, {29'h0, c.sh});
    wr(b + 8'd1, {24'h0, c.en, c.num});
    wr(b + 8'd2, {24'h0, c.cap[7:0]});
    wr(b + 8'd3, {31'h0, c.cap[8]});
    for (int i = 0; i < TSA_MASK_REGS; i++) wr(m + 8'(i), {24'h0, c.mask[8 * i +: 8]});
  endtask : cfgDir
  function automatic logic expAct(tsa_dir_s c, logic md, int n);
    int off;
    off = n - (1 + TSA_SLOT_BITS * c.num + c.sh);
    if (!md || off < 0) return 1'b0;
    if (!c.en) return off <= int'(c.cap);
    return off < TSA_SLOT_BITS * TSA_MASK_SLOTS && c.mask[off / TSA_SLOT_BITS];
  endfunction : expAct
  task automatic runFrame(input int len, input int e);
    int mt;
    int mr;
    mt = 0;
    mr = 0;
    i_tsa_highway.frame(6, len);
    #1;
    for (int p = 2; p < len; p++) begin
      if (txSeen[p] !== expAct(TX_TAB[e], MODE_TAB[e], p - 2)) mt++;
      if (rxSeen[p] !== expAct(RX_TAB[e], MODE_TAB[e], p - 2)) mr++;
    end
    checkEq(mt, 0);
    checkEq(mr, 0);
  endtask : runFrame
  initial begin
    rst = 1'b1;
    linkRst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    i_tsa_highway.runClocks(4);
    linkRst = 1'b0;
    // Read data xor response: a refused read cannot pass as zero
    for (int i = 0; i < 16; i++) rdChk(TSA_TX_SHIFT_IDX + 8'(i), 32'h0);
    wr(TSA_TX_SHIFT_IDX, 32'hff);
    wr(TSA_RX_SHIFT_IDX, 32'hff);
    rdChk(TSA_TX_SHIFT_IDX, 32'h07);
    rdChk(TSA_RX_SHIFT_IDX, 32'h07);
    wr(TSA_TX_START_IDX, 32'hffffff80);
    axiWrite(TSA_TX_START_IDX, 32'h55, 4'h0, resp);
    checkEq({30'h0, resp}, {30'h0, TSA_RESP_OKAY});
    rdChk(TSA_TX_START_IDX, 32'h80);
    axiWrite(8'h01, 32'h1, 4'hf, resp);
    checkEq({30'h0, resp}, {30'h0, TSA_RESP_SLVERR});
    axiRead(8'h01, rdData, resp);
    checkEq({30'h0, resp}, {30'h0, TSA_RESP_SLVERR});
    for (int e = 0; e < 5; e++) begin
      cfgDir(TSA_TX_SHIFT_IDX, TSA_TX_MASK0_IDX, TX_TAB[e]);
      cfgDir(TSA_RX_SHIFT_IDX, TSA_RX_MASK0_IDX, RX_TAB[e]);
      wr(TSA_CTRL_IDX, {31'h0, MODE_TAB[e]});
      // Short frame cuts slots short; next sync must restart the count
      runFrame(40, e);
      runFrame(1100, e);
    end
    tallyAndFinish();
  end
endmodule : tb_tsa_slot_assign
